/* File: rtl/fetch_regs.svh */
// sizes, addresses and timing figures of the flash fetch front end
`ifndef FETCH_REGS_SVH
`define FETCH_REGS_SVH
`define Q_DEPTH 8
`define Q_CNT_W 4
`define TGT_ENTRIES 15
`define TGT_IDX_W 4
`define TGT_WORDS 8
`define TGT_OFF_W 3
`define TGT_OLDEST 4'hE
`define WORD_BYTES 32'h0000_0004
`define LINE_BYTES 32'h0000_0020
`define IRQ_VEC_ADDR 32'hFFFF_FF00
`define IRQ_VEC_INSTR 32'hA5A5_0001
`define BOOT_ADDR 32'h0000_0000
`define FLASH_MAX_MHZ 96
`define REF_CLK_MHZ 100
`endif

/* File: rtl/fetch_pkg.sv */
// types shared by the flash fetch front end
package fetch_pkg;
	typedef logic [31:0] word_t;
	typedef enum logic [2:0] {
		FL_IDLE = 3'b001,
		FL_PREF = 3'b010,
		FL_LIT = 3'b100
	} flash_state_e;
endpackage

/* File: rtl/lookahead_queue.sv */
// eight word circular queue of prefetched instructions
`timescale 1ns/1ps
`include "fetch_regs.svh"
module lookahead_queue import fetch_pkg::*; (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic flush,
	input wire logic push,
	input wire word_t push_data,
	input wire logic pop,
	output word_t head_data,
	output logic [`Q_CNT_W-1:0] count
);
	word_t mem [0:`Q_DEPTH-1];
	logic [2:0] wr_ptr_r;
	logic [2:0] rd_ptr_r;
	logic [`Q_CNT_W-1:0] count_r;
	logic do_push;
	logic do_pop;

	assign do_push = push && !flush && (count_r != 4'h8);
	assign do_pop = pop && !flush && (count_r != 4'h0);
	assign head_data = mem[rd_ptr_r];
	assign count = count_r;

	// storage, no reset needed on data
	always_ff @(posedge ref_clk) begin
		if (do_push) begin
			mem[wr_ptr_r] <= push_data;
		end
	end

	// pointers and fill level, flush empties at once
	always_ff @(posedge ref_clk) begin
		if (rst || flush) begin
			wr_ptr_r <= 3'h0;
			rd_ptr_r <= 3'h0;
			count_r <= 4'h0;
		end else begin
			wr_ptr_r <= wr_ptr_r + 3'(do_push);
			rd_ptr_r <= rd_ptr_r + 3'(do_pop);
			count_r <= count_r + 4'(do_push) - 4'(do_pop);
		end
	end

	q_flush_a: assert property (@(posedge ref_clk) disable iff (rst)
		flush |=> count_r == 4'h0) else $error("queue not empty after flush");
	q_fill_a: assert property (@(posedge ref_clk) disable iff (rst)
		push && !pop && !flush && count_r < 4'h8 |=> count_r == $past(count_r) + 4'h1)
		else $error("queue push lost");
endmodule

/* File: rtl/taken_branch_store.sv */
// fifteen entry store of taken branch targets with their first eight words
`timescale 1ns/1ps
`include "fetch_regs.svh"
module taken_branch_store import fetch_pkg::*; (
	input wire logic ref_clk,
	input wire logic rst,
	input wire word_t look_addr,
	output logic hit,
	output logic [`TGT_IDX_W-1:0] hit_idx,
	input wire logic [`TGT_IDX_W-1:0] rd_idx,
	input wire logic [`TGT_OFF_W-1:0] rd_off,
	output word_t rd_data,
	input wire logic wr_en,
	input wire logic [`TGT_IDX_W-1:0] wr_idx,
	input wire logic [`TGT_OFF_W-1:0] wr_off,
	input wire word_t wr_data,
	input wire logic fill_done,
	input wire logic alloc,
	input wire word_t alloc_addr,
	input wire logic touch,
	input wire logic [`TGT_IDX_W-1:0] touch_idx,
	output logic [`TGT_IDX_W-1:0] victim_idx
);
	word_t data_mem [0:`TGT_ENTRIES*`TGT_WORDS-1];
	word_t tag_r [0:`TGT_ENTRIES-1];
	logic [`TGT_IDX_W-1:0] rank_r [0:`TGT_ENTRIES-1];
	logic [`TGT_ENTRIES-1:0] valid_r;
	logic [`TGT_ENTRIES-1:0] match;

	assign rd_data = data_mem[{rd_idx, rd_off}];

	// stored words of each target
	always_ff @(posedge ref_clk) begin
		if (wr_en) begin
			data_mem[{wr_idx, wr_off}] <= wr_data;
		end
	end

	// per entry tag, valid, compare and recency rank
	for (genvar i = 0; i < `TGT_ENTRIES; i++) begin : g_ent
		assign match[i] = valid_r[i] && (tag_r[i] == look_addr);
		always_ff @(posedge ref_clk) begin
			if (rst) begin
				valid_r[i] <= 1'b0;
				tag_r[i] <= 32'h0000_0000;
			end else if (alloc && victim_idx == 4'(i)) begin
				valid_r[i] <= 1'b0;
				tag_r[i] <= alloc_addr;
			end else if (fill_done && wr_idx == 4'(i)) begin
				valid_r[i] <= 1'b1;
			end
		end
		always_ff @(posedge ref_clk) begin
			if (rst) begin
				rank_r[i] <= 4'(i);
			end else if (touch) begin
				if (touch_idx == 4'(i)) begin
					rank_r[i] <= 4'h0;
				end else if (rank_r[i] < rank_r[touch_idx]) begin
					rank_r[i] <= rank_r[i] + 4'h1;
				end
			end
		end
	end

	// priority encode the match and pick the least recently taken entry
	always_comb begin
		hit = |match;
		hit_idx = 4'h0;
		victim_idx = 4'h0;
		for (int k = 0; k < `TGT_ENTRIES; k++) begin
			if (match[k]) begin
				hit_idx = 4'(k);
			end
			if (rank_r[k] == `TGT_OLDEST) begin
				victim_idx = 4'(k);
			end
		end
	end

	lru_touch_a: assert property (@(posedge ref_clk) disable iff (rst)
		touch |=> rank_r[$past(touch_idx)] == 4'h0) else $error("touched entry not newest");
	fill_hit_a: assert property (@(posedge ref_clk) disable iff (rst)
		fill_done && !alloc |=> valid_r[$past(wr_idx)]) else $error("filled entry not valid");
endmodule

/* File: rtl/flash_fetch_unit.sv */
// instruction fetch front end between core instruction port and burst flash
`timescale 1ns/1ps
`include "fetch_regs.svh"
module flash_fetch_unit import fetch_pkg::*; (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic boot_bank_sel,
	input wire logic ifetch_req,
	input wire word_t ifetch_addr,
	output logic instr_valid_r,
	output word_t instr_data_r,
	input wire logic lit_req,
	input wire word_t lit_addr,
	output logic lit_valid_r,
	output word_t lit_data_r,
	output logic fl_req_r,
	output word_t fl_addr_r,
	output logic fl_bank_r,
	input wire logic fl_rvalid,
	input wire word_t fl_rdata
);

	flash_state_e fl_st_r;
	logic boot_done_r;
	logic bank_r;
	word_t q_head_r;
	word_t pf_addr_r;
	logic drop_r;
	logic tgt_act_r;
	logic [`TGT_IDX_W-1:0] tgt_idx_r;
	logic [`TGT_OFF_W-1:0] tgt_off_r;
	word_t tgt_next_r;
	logic alloc_act_r;
	logic [`TGT_IDX_W-1:0] alloc_idx_r;
	logic [`TGT_OFF_W-1:0] alloc_cnt_r;

	logic take, is_irq, tgt_seq, q_seq, branch;
	logic serve_irq, serve_tgt, serve_q, tgt_hit_take, miss, flush;
	logic lit_take, issue_pref, push, fill_wr, fill_done;
	word_t new_base;
	word_t q_head_data;
	logic [`Q_CNT_W-1:0] q_count;
	logic hit;
	logic [`TGT_IDX_W-1:0] hit_idx, victim_idx, rd_idx;
	logic [`TGT_OFF_W-1:0] rd_off;
	word_t rd_data;

	// boot bank strap is caught on the first cycle after reset release
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			boot_done_r <= 1'b0;
			bank_r <= 1'b0;
		end else if (!boot_done_r) begin
			boot_done_r <= 1'b1;
			bank_r <= boot_bank_sel;
		end
	end

	// classify the core request; one answer per request, so skip the answer cycle
	assign take = boot_done_r && ifetch_req && !instr_valid_r;
	assign is_irq = ifetch_addr == `IRQ_VEC_ADDR;
	assign tgt_seq = tgt_act_r && ifetch_addr == tgt_next_r;
	assign q_seq = !tgt_act_r && ifetch_addr == q_head_r;
	assign branch = take && !is_irq && !tgt_seq && !q_seq;
	assign serve_irq = take && is_irq;
	assign serve_tgt = take && !is_irq && tgt_seq;
	assign serve_q = take && !is_irq && !tgt_seq && q_seq && q_count != 4'h0;
	assign tgt_hit_take = branch && hit;
	assign miss = branch && !hit;
	assign flush = serve_irq || branch;

	// base of the reloaded queue: past the cached words on a hit
	always_comb begin
		if (serve_irq) begin
			new_base = ifetch_addr + `WORD_BYTES;
		end else if (hit) begin
			new_base = ifetch_addr + `LINE_BYTES;
		end else begin
			new_base = ifetch_addr;
		end
	end

	// flash port arbitration: literal first, then prefetch
	assign lit_take = boot_done_r && fl_st_r == FL_IDLE && lit_req && !lit_valid_r;
	assign issue_pref = boot_done_r && fl_st_r == FL_IDLE && !lit_take && !flush
		&& q_count < 4'h8;
	assign push = fl_rvalid && fl_st_r == FL_PREF && !drop_r && !flush;
	assign fill_wr = push && alloc_act_r;
	assign fill_done = fill_wr && alloc_cnt_r == 3'h7;

	// flash transaction state, one word outstanding at a time
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			fl_st_r <= FL_IDLE;
		end else begin
			case (fl_st_r)
				FL_IDLE: begin
					if (lit_take) begin
						fl_st_r <= FL_LIT;
					end else if (issue_pref) begin
						fl_st_r <= FL_PREF;
					end
				end
				FL_PREF, FL_LIT: begin
					if (fl_rvalid) begin
						fl_st_r <= FL_IDLE;
					end
				end
				default: fl_st_r <= FL_IDLE;
			endcase
		end
	end

	// flash request outputs
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			fl_req_r <= 1'b0;
			fl_addr_r <= `BOOT_ADDR;
			fl_bank_r <= 1'b0;
		end else begin
			fl_req_r <= lit_take || issue_pref;
			fl_bank_r <= bank_r;
			if (lit_take) begin
				fl_addr_r <= {lit_addr[31:2], 2'b00};
			end else if (issue_pref) begin
				fl_addr_r <= pf_addr_r;
			end
		end
	end

	// a prefetch in flight across a flush returns stale data and is dropped
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			drop_r <= 1'b0;
		end else if (flush && fl_st_r == FL_PREF && !fl_rvalid) begin
			drop_r <= 1'b1;
		end else if (fl_rvalid) begin
			drop_r <= 1'b0;
		end
	end

	// queue head and next prefetch address
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			q_head_r <= `BOOT_ADDR;
			pf_addr_r <= `BOOT_ADDR;
		end else if (flush) begin
			q_head_r <= new_base;
			pf_addr_r <= new_base;
		end else begin
			if (serve_q) begin
				q_head_r <= q_head_r + `WORD_BYTES;
			end
			if (issue_pref) begin
				pf_addr_r <= pf_addr_r + `WORD_BYTES;
			end
		end
	end

	// cached burst after a hit: words 1..7 come from the store
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			tgt_act_r <= 1'b0;
			tgt_idx_r <= 4'h0;
			tgt_off_r <= 3'h0;
			tgt_next_r <= 32'h0000_0000;
		end else if (tgt_hit_take) begin
			tgt_act_r <= 1'b1;
			tgt_idx_r <= hit_idx;
			tgt_off_r <= 3'h1;
			tgt_next_r <= ifetch_addr + `WORD_BYTES;
		end else if (flush) begin
			tgt_act_r <= 1'b0;
		end else if (serve_tgt) begin
			tgt_off_r <= tgt_off_r + 3'h1;
			tgt_next_r <= tgt_next_r + `WORD_BYTES;
			if (tgt_off_r == 3'h7) begin
				tgt_act_r <= 1'b0;
			end
		end
	end

	// entry allocation on a miss, filled from the first eight prefetched words
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			alloc_act_r <= 1'b0;
			alloc_idx_r <= 4'h0;
			alloc_cnt_r <= 3'h0;
		end else if (miss) begin
			alloc_act_r <= 1'b1;
			alloc_idx_r <= victim_idx;
			alloc_cnt_r <= 3'h0;
		end else if (flush || fill_done) begin
			alloc_act_r <= 1'b0;
		end else if (fill_wr) begin
			alloc_cnt_r <= alloc_cnt_r + 3'h1;
		end
	end

	// instruction answer, a miss stalls until the queue holds the target
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			instr_valid_r <= 1'b0;
			instr_data_r <= 32'h0000_0000;
		end else begin
			instr_valid_r <= serve_irq || serve_tgt || tgt_hit_take || serve_q;
			if (serve_irq) begin
				instr_data_r <= `IRQ_VEC_INSTR;
			end else if (serve_tgt || tgt_hit_take) begin
				instr_data_r <= rd_data;
			end else if (serve_q) begin
				instr_data_r <= q_head_data;
			end
		end
	end

	// literal answer bypasses the queue entirely
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			lit_valid_r <= 1'b0;
			lit_data_r <= 32'h0000_0000;
		end else begin
			lit_valid_r <= fl_rvalid && fl_st_r == FL_LIT;
			if (fl_rvalid && fl_st_r == FL_LIT) begin
				lit_data_r <= fl_rdata;
			end
		end
	end

	assign rd_idx = serve_tgt ? tgt_idx_r : hit_idx;
	assign rd_off = serve_tgt ? tgt_off_r : 3'h0;

	// prefetch queue on the instruction tight port path
	lookahead_queue u_queue (
		.ref_clk(ref_clk),
		.rst(rst),
		.flush(flush),
		.push(push),
		.push_data(fl_rdata),
		.pop(serve_q),
		.head_data(q_head_data),
		.count(q_count)
	);

	taken_branch_store u_store (
		.ref_clk(ref_clk),
		.rst(rst),
		.look_addr(ifetch_addr),
		.hit(hit),
		.hit_idx(hit_idx),
		.rd_idx(rd_idx),
		.rd_off(rd_off),
		.rd_data(rd_data),
		.wr_en(fill_wr),
		.wr_idx(alloc_idx_r),
		.wr_off(alloc_cnt_r),
		.wr_data(fl_rdata),
		.fill_done(fill_done),
		.alloc(miss),
		.alloc_addr(ifetch_addr),
		.touch(miss || tgt_hit_take),
		.touch_idx(miss ? victim_idx : hit_idx),
		.victim_idx(victim_idx)
	);

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence irq_ask_s;
		take ##0 is_irq;
	endsequence
	sequence irq_ans_s;
		instr_valid_r ##0 instr_data_r == `IRQ_VEC_INSTR;
	endsequence

	irq_entry_a: assert property (irq_ask_s |=> irq_ans_s ##0 (!fl_req_r || fl_st_r == FL_LIT))
		else $error("vector read not served at once");
	queue_bound_a: assert property (q_count <= 4'h8)
		else $error("queue over eight words");
	idle_fetch_a: assert property (issue_pref |=> fl_req_r ##0 fl_addr_r == $past(pf_addr_r))
		else $error("prefetch not issued");
	one_word_a: assert property (fl_req_r |-> fl_st_r != FL_IDLE ##1 !fl_req_r)
		else $error("second flash read while one outstanding");
	hit_reload_a: assert property (tgt_hit_take |=> instr_valid_r && tgt_act_r
		&& pf_addr_r == $past(ifetch_addr) + `LINE_BYTES) else $error("hit reload wrong");
	miss_stall_a: assert property (miss |=> !instr_valid_r && alloc_act_r
		&& q_head_r == $past(ifetch_addr)) else $error("miss not stalled");
	literal_keep_a: assert property (lit_take && !flush && !serve_q |=> $stable(q_head_r))
		else $error("literal disturbed queue");
	boot_bank_a: assert property (fl_req_r |-> boot_done_r && fl_bank_r == bank_r)
		else $error("fetch before boot bank known");
	word_push_a: assert property (push && !serve_q |=> q_count == $past(q_count) + 4'h1)
		else $error("flash read did not add one word");
endmodule

/* File: tb/flash_model.sv */
// burst flash partner model answering one word read at a time
`timescale 1ns/1ps
module flash_model import fetch_pkg::*; (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic slow,
	input wire logic fl_req_r,
	input wire word_t fl_addr_r,
	input wire logic fl_bank_r,
	output logic fl_rvalid,
	output word_t fl_rdata
);
	word_t addr_r;
	logic bank_r;
	logic busy_r;
	logic [3:0] wait_r;

	// one read in flight; data lines toggle between answers so stale data never matches
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			busy_r <= 1'b0;
			wait_r <= 4'h0;
			fl_rvalid <= 1'b0;
			fl_rdata <= 32'h0000_0000;
			addr_r <= 32'h0000_0000;
			bank_r <= 1'b0;
		end else begin
			fl_rvalid <= 1'b0;
			fl_rdata <= ~fl_rdata;
			if (fl_req_r && !busy_r) begin
				busy_r <= 1'b1;
				addr_r <= fl_addr_r;
				bank_r <= fl_bank_r;
				wait_r <= slow ? 4'h5 : 4'h0;
			end else if (busy_r) begin
				if (wait_r == 4'h0) begin
					busy_r <= 1'b0;
					fl_rvalid <= 1'b1;
					fl_rdata <= addr_r ^ 32'hC3C3_0000 ^ {31'h0, bank_r}; // one 32-bit word
				end else begin
					wait_r <= wait_r - 4'h1;
				end
			end
		end
	end
endmodule

/* File: tb/flash_fetch_prefetch_branch_cache_test.sv */
// self-checking bench for the flash fetch front end
`timescale 1ns/1ps
`include "fetch_regs.svh"
module flash_fetch_prefetch_branch_cache_test import fetch_pkg::*;;
	logic ref_clk = 1'b0;
	logic rst, boot_bank_sel, ifetch_req, lit_req, slow;
	word_t ifetch_addr, lit_addr;
	logic instr_valid_r, lit_valid_r, fl_req_r, fl_bank_r, fl_rvalid;
	word_t instr_data_r, lit_data_r, fl_addr_r, fl_rdata;
	int mismatches = 0;
	int check_count = 0;
	int cyc_count = 0;
	int req_cnt = 0;
	word_t first_addr, watch_addr;
	logic first_bank, watch_hit;

	always #5 ref_clk = ~ref_clk;

	flash_fetch_unit dut (.ref_clk(ref_clk), .rst(rst), .boot_bank_sel(boot_bank_sel),
		.ifetch_req(ifetch_req), .ifetch_addr(ifetch_addr), .instr_valid_r(instr_valid_r),
		.instr_data_r(instr_data_r), .lit_req(lit_req), .lit_addr(lit_addr),
		.lit_valid_r(lit_valid_r), .lit_data_r(lit_data_r), .fl_req_r(fl_req_r),
		.fl_addr_r(fl_addr_r), .fl_bank_r(fl_bank_r), .fl_rvalid(fl_rvalid),
		.fl_rdata(fl_rdata));

	flash_model flash (.ref_clk(ref_clk), .rst(rst), .slow(slow), .fl_req_r(fl_req_r),
		.fl_addr_r(fl_addr_r), .fl_bank_r(fl_bank_r), .fl_rvalid(fl_rvalid),
		.fl_rdata(fl_rdata));

	// expected flash content, same pattern the model stores
	function automatic word_t flash_word(input word_t a, input logic b);
		return a ^ 32'hC3C3_0000 ^ {31'h0, b};
	endfunction

	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic check_word(input string name, input word_t exp, input word_t got);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic check_num(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %0d seen %0d", name, exp, got);
		end
	endtask

	// flash request watcher and run ceiling
	always @(posedge ref_clk) begin
		cyc_count++;
		if (fl_req_r === 1'b1) begin
			req_cnt++;
			if (req_cnt == 1) begin
				first_addr = fl_addr_r;
				first_bank = fl_bank_r;
			end
			if (fl_addr_r === watch_addr) watch_hit = 1'b1;
		end
		if (cyc_count == 20000) begin
			mismatches++;
			stop_test();
		end
	end

	// core fetch: hold request until the answer is sampled, count edges taken
	task automatic fetch(input word_t a, output word_t d, output int n);
		ifetch_req <= 1'b1;
		ifetch_addr <= a;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (instr_valid_r !== 1'b1);
		d = instr_data_r;
	endtask

	// sequential run of words, optionally each served at the two-edge hit pace
	task automatic run(input word_t base, input int cnt, input bit fast);
		word_t d;
		int n;
		for (int i = 0; i < cnt; i++) begin
			fetch(base + word_t'(i) * `WORD_BYTES, d, n);
			check_word("instr_data", flash_word(base + word_t'(i) * `WORD_BYTES, 1'b1), d);
			if (fast) check_num("fast_latency", 2, n);
		end
	endtask

	task automatic idle(input int n);
		ifetch_req <= 1'b0;
		repeat (n) @(posedge ref_clk);
	endtask

	task automatic lit(input word_t a, output word_t d);
		lit_req <= 1'b1;
		lit_addr <= a;
		do @(posedge ref_clk); while (lit_valid_r !== 1'b1);
		d = lit_data_r;
		lit_req <= 1'b0;
	endtask

	task automatic s_boot();
		repeat (20) if (req_cnt == 0) @(posedge ref_clk);
		check_word("boot_addr", `BOOT_ADDR, first_addr);
		check_word("boot_bank", 32'h0000_0001, {31'h0, first_bank});
	endtask

	// queue fills eight deep while the core is idle
	task automatic s_seq();
		run(32'h0000_0000, 8, 1'b0);
		idle(80);
		run(32'h0000_0020, 8, 1'b1);
	endtask

	task automatic s_branch();
		word_t d;
		int n;
		watch_addr = 32'h0000_1000;
		watch_hit = 1'b0;
		fetch(32'h0000_1000, d, n);
		check_word("miss_data", flash_word(32'h0000_1000, 1'b1), d);
		check_num("miss_stall", 1, int'(n > 2));
		check_num("miss_read", 1, 32'(watch_hit));
		run(32'h0000_1004, 7, 1'b0);
		fetch(32'h0000_2000, d, n);
		check_word("miss2_data", flash_word(32'h0000_2000, 1'b1), d);
		run(32'h0000_1000, 8, 1'b1);
		run(32'h0000_1020, 1, 1'b0);
		idle(4);
	endtask

	task automatic s_irq();
		word_t d;
		int n;
		watch_addr = `IRQ_VEC_ADDR;
		watch_hit = 1'b0;
		fetch(`IRQ_VEC_ADDR, d, n);
		check_word("irq_instr", `IRQ_VEC_INSTR, d);
		check_num("irq_latency", 2, n);
		run(`IRQ_VEC_ADDR + `WORD_BYTES, 1, 1'b0);
		check_num("irq_read", 0, 32'(watch_hit));
		idle(4);
	endtask

	// literal read through a slow flash must leave the full queue intact
	task automatic s_lit();
		word_t d;
		run(32'h0000_3000, 1, 1'b0);
		idle(80);
		slow <= 1'b1;
		watch_addr = 32'h0000_8000;
		watch_hit = 1'b0;
		lit(32'h0000_8000, d);
		check_word("lit_data", flash_word(32'h0000_8000, 1'b1), d);
		check_num("lit_read", 1, 32'(watch_hit));
		run(32'h0000_3004, 8, 1'b1);
		slow <= 1'b0;
		idle(4);
	endtask

	// sixteen targets: oldest evicted, the second target still kept
	task automatic s_lru();
		word_t d;
		int n;
		for (int i = 0; i < 16; i++) run(32'h0001_0000 + (word_t'(i) << 8), 8, 1'b0);
		run(32'h0001_0100, 1, 1'b1);
		watch_addr = 32'h0001_0000;
		watch_hit = 1'b0;
		fetch(32'h0001_0000, d, n);
		check_num("evicted_stall", 1, int'(n > 2));
		check_num("evicted_read", 1, 32'(watch_hit));
		idle(4);
	endtask

	initial begin
		rst = 1'b1;
		boot_bank_sel = 1'b1;
		ifetch_req = 1'b0;
		ifetch_addr = 32'h0000_0000;
		lit_req = 1'b0;
		lit_addr = 32'h0000_0000;
		slow = 1'b0;
		watch_addr = 32'hFFFF_FFFC;
		watch_hit = 1'b0;
		first_addr = 32'hFFFF_FFFF;
		first_bank = 1'b0;
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		s_boot();
		s_seq();
		s_branch();
		s_irq();
		s_lit();
		s_lru();
		stop_test();
	end
endmodule
